// ---- pin_function_decode.sv ----
module pin_function_decode
  import pin_mux_pkg::*;
#(
   parameter logic [7:0] LEGAL = 8'h1f
)
(
   input  wire logic [2:0]              code,
   output pin_mux_pkg::pin_route_type   route
);

   logic [7:0] oneHot;

   always_comb
   begin
      oneHot = 8'(8'h01 << code) & LEGAL;
      route  = pin_route_type'(oneHot[ROUTE_W-1:0]);
   end

endmodule

// ---- pin_function_select.sv ----
// Chosen here: the APB slave port.
module pin_function_select
(
   input  wire logic                                  core_clk,
   input  wire logic                                  rst_n,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [pin_mux_pkg::ADDR_W-1:0]        paddr,
   input  wire logic [pin_mux_pkg::DATA_W-1:0]        pwdata,
   output logic      [pin_mux_pkg::DATA_W-1:0]        prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   output pin_mux_pkg::pin_route_type [pin_mux_pkg::PIN_COUNT-1:0] pinRoute
);
   import pin_mux_pkg::*;

   logic [HALF_W-1:0]          groupBUpper;
   logic [HALF_W-1:0]          groupCLower;
   logic [HALF_W-1:0]          next_groupBUpper;
   logic [HALF_W-1:0]          next_groupCLower;
   logic [DATA_W-1:0]          next_prdata;
   logic                       next_pready;
   logic                       next_pslverr;
   pin_route_type [PIN_COUNT-1:0] next_pinRoute;

   logic                       setupPhase;
   logic                       writeTaken;
   logic                       hitB;
   logic                       hitC;
   logic [HALF_W-1:0]          writeEnable;
   logic [HALF_W-1:0]          writeValue;
   logic [SEL_W-1:0]           pinCode [PIN_COUNT];

   assign hitB        = (paddr == B_UPPER_OFFSET);
   assign hitC        = (paddr == C_LOWER_OFFSET);
   assign setupPhase  = psel && !penable;
   // write lands only at the edge that closes the access phase
   assign writeTaken  = psel && penable && pready && pwrite;
   assign writeEnable = pwdata[DATA_W-1:WE_LSB];
   assign writeValue  = pwdata[HALF_W-1:0];

   // register bus: no wait states, answer prepared during setup
   always_comb
   begin
      next_pready  = setupPhase;
      next_pslverr = setupPhase && !(hitB || hitC);
      next_prdata  = '0;
      if (setupPhase && !pwrite)
      begin
         if (hitB)
         begin
            next_prdata = {16'h0000, groupBUpper};
         end
         else if (hitC)
         begin
            next_prdata = {16'h0000, groupCLower};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // select words; masking keeps the reserved bits at zero for good
   always_comb
   begin
      next_groupBUpper = groupBUpper;
      next_groupCLower = groupCLower;
      if (writeTaken && hitB)
      begin
         next_groupBUpper = ((groupBUpper & ~writeEnable)
                            | (writeValue & writeEnable))
                            & B_UPPER_RW_MASK;
      end
      if (writeTaken && hitC)
      begin
         next_groupCLower = ((groupCLower & ~writeEnable)
                            | (writeValue & writeEnable))
                            & C_LOWER_RW_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         groupBUpper <= SEL_RESET;
         groupCLower <= SEL_RESET;
      end
      else
      begin
         groupBUpper <= next_groupBUpper;
         groupCLower <= next_groupCLower;
      end
   end

   assign pinCode[0] = groupBUpper[B7_LSB +: SEL_W];
   assign pinCode[1] = groupCLower[C0_LSB +: SEL_W];
   assign pinCode[2] = groupCLower[C1_LSB +: SEL_W];
   assign pinCode[3] = groupCLower[C2_LSB +: SEL_W];
   assign pinCode[4] = groupCLower[C3_LSB +: SEL_W];
   assign pinCode[5] = groupCLower[C4_LSB +: SEL_W];

   // per-pin decode; each pin carries its own table of legal codes
   genvar pinIdx;
   generate
      for (pinIdx = 0; pinIdx < PIN_COUNT; pinIdx++)
      begin : g_pin
         pin_function_decode #(
            .LEGAL (PIN_LEGAL[pinIdx])
         ) u_decode (
            .code  (pinCode[pinIdx]),
            .route (next_pinRoute[pinIdx])
         );
      end
   endgenerate

   // routes are registered so the pad mux never sees decode glitches
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinRoute <= {PIN_COUNT{pin_route_type'(5'h01)}};
      end
      else
      begin
         pinRoute <= next_pinRoute;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence writeB;
      psel && penable && pready && pwrite && hitB;
   endsequence

   sequence writeC;
      psel && penable && pready && pwrite && hitC;
   endsequence

   sequence readSetup;
      psel && !penable && !pwrite && (hitB || hitC);
   endsequence

   we_keep_a: assert property (
      writeC |=> ((groupCLower ^ $past(groupCLower))
                  & ~$past(writeEnable)) == 16'h0000)
      else $error("unenabled select bit changed");

   we_apply_a: assert property (
      writeB |=> (groupBUpper & $past(writeEnable) & B_UPPER_RW_MASK)
                 == ($past(writeValue) & $past(writeEnable)
                     & B_UPPER_RW_MASK))
      else $error("enabled select bit not written");

   reserved_zero_a: assert property (
      (writeB or writeC) |=> groupBUpper[15:3] == 13'h0000
                             && groupCLower[15] == 1'b0)
      else $error("reserved select bit set");

   b7_route_a: assert property (
      groupBUpper[2:0] == 3'b100 |=> pinRoute[0].alt4 && !pinRoute[0].gpio)
      else $error("pin b7 not routed to camera clock");

   c4_route_a: assert property (
      groupCLower[14:12] == 3'b011 |=> pinRoute[5].alt3 && !pinRoute[5].alt1)
      else $error("pin c4 not routed to card reset");

   c3_route_a: assert property (
      groupCLower[11:9] == 3'b010 |=> pinRoute[4].alt2 && !pinRoute[4].gpio)
      else $error("pin c3 not routed to pdm data 0");

   c2_route_a: assert property (
      groupCLower[8:6] == 3'b100 |=> pinRoute[3].alt4 && !pinRoute[3].alt3)
      else $error("pin c2 not routed to camera data 7");

   c1_route_a: assert property (
      groupCLower[5:3] == 3'b010 |=> pinRoute[2].alt2 && !pinRoute[2].alt1)
      else $error("pin c1 not routed to spdif");

   c0_route_a: assert property (
      groupCLower[2:0] == 3'b011 |=> pinRoute[1].alt3 && !pinRoute[1].alt4)
      else $error("pin c0 not routed to stream d5");

   reserved_idle_a: assert property (
      groupBUpper[2:0] == 3'b010 |=> pinRoute[0] == pin_route_type'(5'h00))
      else $error("reserved code drives a function");

   c_reserved_a: assert property (
      groupCLower[2:0] == 3'b111 |=> pinRoute[1] == pin_route_type'(5'h00))
      else $error("reserved code drives a function on pin c0");

   read_half_a: assert property (
      readSetup ##1 penable |-> pready && prdata[31:16] == 16'h0000
                 && prdata[15:0] == ($past(hitB) ? groupBUpper : groupCLower))
      else $error("read data wrong");

endmodule

// ---- pin_mux_pkg.sv ----
package pin_mux_pkg;

   localparam int              ADDR_W       = 12;
   localparam int              DATA_W       = 32;
   localparam int              HALF_W       = 16;
   localparam int              WE_LSB       = 16;
   localparam int              SEL_W        = 3;
   localparam int              PIN_COUNT    = 6;
   localparam int              ROUTE_W      = 5;
   localparam int              CODE_SPAN    = 8;

   // byte offsets of the two select words
   localparam logic [11:0]     B_UPPER_OFFSET = 12'h028;
   localparam logic [11:0]     C_LOWER_OFFSET = 12'h02c;

   // writable selector bits; everything else is reserved and reads zero
   localparam logic [15:0]     B_UPPER_RW_MASK = 16'h0007;
   localparam logic [15:0]     C_LOWER_RW_MASK = 16'h7fff;
   localparam logic [15:0]     SEL_RESET       = 16'h0000;

   // selector field positions inside the low half
   localparam int              B7_LSB = 0;
   localparam int              C0_LSB = 0;
   localparam int              C1_LSB = 3;
   localparam int              C2_LSB = 6;
   localparam int              C3_LSB = 9;
   localparam int              C4_LSB = 12;

   // routing codes
   localparam logic [2:0]      CODE_GPIO = 3'h0;
   localparam logic [2:0]      CODE_ALT1 = 3'h1;
   localparam logic [2:0]      CODE_ALT2 = 3'h2;
   localparam logic [2:0]      CODE_ALT3 = 3'h3;
   localparam logic [2:0]      CODE_ALT4 = 3'h4;

   // bit k set means code k routes somewhere on that pin
   localparam logic [7:0]      B7_LEGAL = 8'h1b;
   localparam logic [7:0]      C4_LEGAL = 8'h0f;
   localparam logic [7:0]      C3_LEGAL = 8'h0f;
   localparam logic [7:0]      C2_LEGAL = 8'h1f;
   localparam logic [7:0]      C1_LEGAL = 8'h1f;
   localparam logic [7:0]      C0_LEGAL = 8'h1b;

   // pin order in the route vector: b7, c0, c1, c2, c3, c4
   localparam logic [7:0]      PIN_LEGAL [PIN_COUNT] =
      '{B7_LEGAL, C0_LEGAL, C1_LEGAL, C2_LEGAL, C3_LEGAL, C4_LEGAL};

   // one-hot routing of a pin; all zero on a reserved code
   // alt1: audio master clk / rx frame / tx frame / bit clk / sdi / line1
   // alt2: spdif tx, pdm clock, pdm data 0, pdm data 1
   // alt3: ts sync / ts d5..d7, card clock, card reset
   // alt4: camera clock out / camera data 5..7
   typedef struct packed {
      logic alt4;
      logic alt3;
      logic alt2;
      logic alt1;
      logic gpio;
   } pin_route_type;

endpackage

// ---- tb_pin_function_select.sv ----
module tb_pin_function_select;
   timeunit 1ns;
   timeprecision 1ns;
   import pin_mux_pkg::*;

   logic                      core_clk = 1'b0;
   logic                      rst_n    = 1'b0;
   logic                      psel     = 1'b0;
   logic                      penable  = 1'b0;
   logic                      pwrite   = 1'b0;
   logic [11:0]               paddr    = 12'h000;
   logic [31:0]               pwdata   = 32'h0000_0000;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   pin_route_type [5:0]       pinRoute;
   int                        errTotal  = 0;
   int                        numChecks = 0;
   int                        cycles    = 0;
   logic [31:0]               rd;
   logic                      er;

   pin_function_select uut
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .pinRoute (pinRoute)
   );

   always #10 core_clk = ~core_clk;

   task automatic stopTest();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hung handshake would otherwise stall the run forever
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errTotal++;
         stopTest();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      numChecks++;
      if (g !== e)
      begin
         errTotal++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one idle edge after each transfer keeps psel from being driven twice
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // pready ends the wait; only the cycle ceiling ends a wait that never gets it
      while (pready !== 1'b1)
      begin
         @(posedge core_clk);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      // the answer stands for one cycle only
      chk("pready low", 32'h0, {31'h0, pready});
   endtask

   task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(nm, e, rd);
      chk("slverr", 32'h0, {31'h0, er});
   endtask

   function automatic logic [29:0] expRoute(input logic [2:0] c);
      logic [7:0] legal [6];
      // index order b7, c0, c1, c2, c3, c4
      legal = '{8'h1b, 8'h1b, 8'h1f, 8'h1f, 8'h0f, 8'h0f};
      for (int i = 0; i < 6; i++)
         expRoute[i*5 +: 5] = legal[i][c] ? (5'h01 << c) : 5'h00;
   endfunction

   task automatic doReset();
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rdChk("b reset", 12'h028, 32'h0);
      rdChk("c reset", 12'h02c, 32'h0);
      chk("route reset", 32'h0210_8421, {2'b0, pinRoute});
      $display("test reset done");
   endtask

   task automatic testMask();
      apb(12'h02c, 1'b1, 32'h0000_7fff);
      rdChk("c no enable", 12'h02c, 32'h0);
      apb(12'h02c, 1'b1, 32'h01c0_7fff);
      rdChk("c field enable", 12'h02c, 32'h0000_01c0);
      apb(12'h028, 1'b1, 32'hffff_ffff);
      rdChk("b reserved", 12'h028, 32'h0000_0007);
      apb(12'h02c, 1'b1, 32'hffff_ffff);
      rdChk("c reserved", 12'h02c, 32'h0000_7fff);
      apb(12'h02c, 1'b1, 32'h0001_0000);
      rdChk("c bit clear", 12'h02c, 32'h0000_7ffe);
      $display("test mask done");
   endtask

   task automatic testRoutes();
      logic [2:0] c;
      for (int k = 0; k < 8; k++)
      begin
         c = k[2:0];
         apb(12'h028, 1'b1, {16'h0007, 13'h0, c});
         apb(12'h02c, 1'b1, {16'h7fff, 1'b0, c, c, c, c, c});
         @(posedge core_clk);
         chk("route", {2'b0, expRoute(c)}, {2'b0, pinRoute});
         rdChk("c code", 12'h02c, {17'h0, c, c, c, c, c});
      end
      $display("test routes done");
   endtask

   task automatic testUnmapped();
      apb(12'h030, 1'b1, 32'hffff_ffff);
      chk("wr slverr", 32'h1, {31'h0, er});
      apb(12'h024, 1'b0, 32'h0);
      chk("rd slverr", 32'h1, {31'h0, er});
      chk("rd data", 32'h0, rd);
      rdChk("c kept", 12'h02c, 32'h0000_7fff);
      $display("test unmapped done");
   endtask

   initial
   begin
      doReset();
      testMask();
      testRoutes();
      testUnmapped();
      doReset();
      stopTest();
   end
endmodule
